// File: common/eeprom_pkg.sv
// ****************************************************************************
// ****************************************************************************
package eeprom_pkg;

   // Array shape.
   localparam int unsigned DATA_WIDTH = 16;
   localparam int unsigned ADDR_WIDTH = 6;
   localparam int unsigned REG_COUNT = 64;
   localparam int unsigned INSTR_BITS = 9;

   // Opcode codes.
   localparam logic [1:0] OP_EXTENDED = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;

   // Extended function codes in address bits 5:4.
   localparam logic [1:0] FN_DISABLE_WRITES = 2'h0;
   localparam logic [1:0] FN_WRITE_ALL = 2'h1;
   localparam logic [1:0] FN_ERASE_ALL = 2'h2;
   localparam logic [1:0] FN_ENABLE_WRITES = 2'h3;

   // Erased word value.
   localparam logic [15:0] ERASED_WORD = 16'hffff;

   // Timing at the 10 MHz system clock.
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned PROG_TIME_MS = 12;
   localparam int unsigned PROG_TIME_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned PROG_DEFAULT_CYCLES = PROG_TIME_CYCLES / 2;
   localparam int unsigned CS_LOW_TIME_NS = 1000;
   localparam int unsigned CS_LOW_CYCLES = (CS_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SCLK_HALF_CYCLES = 4;

   // Buffer geometry.
   localparam int unsigned FIFO_DEPTH = 32;

   // Host command kinds.
   typedef enum logic [2:0] {
      CMD_READ,
      CMD_WRITE,
      CMD_ERASE,
      CMD_ENABLE_WRITES,
      CMD_DISABLE_WRITES,
      CMD_ERASE_ALL,
      CMD_WRITE_ALL
   } cmd_type;

endpackage

// File: common/serial_link_if.sv
// ****************************************************************************
// Serial link between host and memory
// ****************************************************************************
interface serial_link_if;
   logic chip_select;
   logic serial_clock;
   logic serial_in;
   logic serial_out_o;
   logic serial_out_oe_n;
   logic serial_out;

   // Wire level: pulled high when the memory does not drive.
   assign serial_out = serial_out_oe_n ? 1'b1 : serial_out_o;

   modport memory (
      input chip_select,
      input serial_clock,
      input serial_in,
      output serial_out_o,
      output serial_out_oe_n
   );

   modport host (
      output chip_select,
      output serial_clock,
      output serial_in,
      input serial_out
   );
endinterface

// File: design/sync_fifo.sv
// ****************************************************************************
// Synchronous FIFO with valid and ready on both sides
// ****************************************************************************
module sync_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Fill side.
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side.
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int unsigned PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [PW:0] cnt_q, cnt_d;
   logic push, pop;

   // Handshakes and next pointers.
   always_comb begin
      push = i_in_valid && (cnt_q != (PW+1)'(DEPTH));
      pop = i_out_ready && (cnt_q != '0);
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
   end

   // Pointer registers.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage, written without reset.
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   assign o_in_ready = (cnt_q != (PW+1)'(DEPTH));
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data = mem_q[rd_q];
endmodule

// File: design/eeprom_memory.sv
// ****************************************************************************
// Serial memory end: 64 registers of 16 bits
// ****************************************************************************
module eeprom_memory #(
   parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_DEFAULT_CYCLES
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Serial link.
   serial_link_if.memory link,
   // Status.
   output logic o_busy,
   output logic o_writes_enabled
);
   import eeprom_pkg::*;

   typedef enum {
      ST_WAIT_START,
      ST_INSTR,
      ST_DATA,
      ST_READ_OUT,
      ST_ARMED,
      ST_DONE
   } state_type;

   logic [DATA_WIDTH-1:0] array_q [REG_COUNT];
   logic [2:0] cs_sync_q, sclk_sync_q, sin_sync_q;
   logic cs, sclk_rise, in_bit, cs_fall;
   state_type state_q, state_d;
   logic [7:0] instr_q, instr_d;
   logic [4:0] cnt_q, cnt_d;
   logic [DATA_WIDTH-1:0] shift_q, shift_d;
   logic [DATA_WIDTH:0] rd_q, rd_d;
   logic en_q, en_d;
   logic prog_q, prog_d;
   logic [22:0] timer_q, timer_d;
   logic out_q, out_d, oe_n_q, oe_n_d;
   logic do_commit;
   logic [1:0] op;
   logic [ADDR_WIDTH-1:0] addr;

   // Link inputs pass two flip-flops; the third stage only feeds edge finding.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cs_sync_q <= '0;
         sclk_sync_q <= '0;
         sin_sync_q <= '0;
      end else begin
         cs_sync_q <= {cs_sync_q[1:0], link.chip_select};
         sclk_sync_q <= {sclk_sync_q[1:0], link.serial_clock};
         sin_sync_q <= {sin_sync_q[1:0], link.serial_in};
      end
   end

   assign cs = cs_sync_q[1];
   assign in_bit = sin_sync_q[1];
   assign sclk_rise = sclk_sync_q[1] && !sclk_sync_q[2];
   assign cs_fall = !cs_sync_q[1] && cs_sync_q[2];
   assign op = instr_q[7:6];
   assign addr = instr_q[5:0];

   // Sequencer: shifting, decoding, output and the self-timed cycle.
   always_comb begin
      state_d = state_q;
      instr_d = instr_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      rd_d = rd_q;
      en_d = en_q;
      prog_d = prog_q;
      timer_d = timer_q;
      out_d = out_q;
      oe_n_d = 1'b1;
      do_commit = 1'b0;
      if (prog_q) begin
         // Cycle runs on the system clock alone.
         if (timer_q == 23'(PROG_CYCLES - 1)) begin
            prog_d = 1'b0;
            do_commit = 1'b1;
         end else begin
            timer_d = timer_q + 23'h1;
         end
         // Status on the pin while select is high.
         oe_n_d = !cs;
         out_d = 1'b0;
      end else if (!cs) begin
         // Standby with select low; armed programming starts on the fall.
         if (state_q == ST_ARMED && cs_fall) begin
            prog_d = 1'b1;
            timer_d = '0;
         end
         state_d = ST_WAIT_START;
      end else begin
         case (state_q)
            ST_WAIT_START: begin
               if (sclk_rise && in_bit) begin
                  cnt_d = '0;
                  state_d = ST_INSTR;
               end
            end
            ST_INSTR: begin
               if (sclk_rise) begin
                  instr_d = {instr_q[6:0], in_bit};
                  cnt_d = cnt_q + 5'h1;
                  if (cnt_q == 5'(INSTR_BITS - 2)) begin
                     cnt_d = '0;
                     state_d = ST_DONE;
                     case (instr_q[6:5])
                        OP_READ: begin
                           rd_d = {1'b0, array_q[{instr_q[4:0], in_bit}]};
                           state_d = ST_READ_OUT;
                        end
                        OP_WRITE: state_d = ST_DATA;
                        OP_ERASE: state_d = en_q ? ST_ARMED : ST_DONE;
                        default: begin
                           case (instr_q[4:3])
                              FN_ENABLE_WRITES: en_d = 1'b1;
                              FN_DISABLE_WRITES: en_d = 1'b0;
                              FN_ERASE_ALL: state_d = en_q ? ST_ARMED : ST_DONE;
                              default: state_d = ST_DATA;
                           endcase
                        end
                     endcase
                  end
               end
            end
            ST_DATA: begin
               if (sclk_rise) begin
                  shift_d = {shift_q[DATA_WIDTH-2:0], in_bit};
                  cnt_d = cnt_q + 5'h1;
                  if (cnt_q == 5'(DATA_WIDTH - 1)) begin
                     state_d = en_q ? ST_ARMED : ST_DONE;
                  end
               end
            end
            ST_READ_OUT: begin
               oe_n_d = 1'b0;
               out_d = rd_q[DATA_WIDTH];
               if (sclk_rise) begin
                  rd_d = {rd_q[DATA_WIDTH-1:0], 1'b0};
               end
            end
            ST_ARMED: begin
               // A further rising clock edge before select drops cancels the cycle.
               if (sclk_rise) begin
                  state_d = ST_DONE;
               end
            end
            default: state_d = state_q;
         endcase
      end
      if (prog_d) begin
         oe_n_d = !cs;
      end else if (prog_q) begin
         // Completed: ready shown while select stays high.
         oe_n_d = !cs;
         out_d = 1'b1;
      end
   end

   // State registers; the enable latch clears at reset.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= ST_WAIT_START;
         instr_q <= '0;
         cnt_q <= '0;
         shift_q <= '0;
         rd_q <= '0;
         en_q <= 1'b0;
         prog_q <= 1'b0;
         timer_q <= '0;
         out_q <= 1'b1;
         oe_n_q <= 1'b1;
      end else begin
         state_q <= state_d;
         instr_q <= instr_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         rd_q <= rd_d;
         en_q <= en_d;
         prog_q <= prog_d;
         timer_q <= timer_d;
         out_q <= out_d;
         oe_n_q <= oe_n_d;
      end
   end

   // Array update at the end of a cycle, one generate entry per register.
   for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
      always_ff @(posedge i_clk) begin
         if (do_commit) begin
            if (op == OP_ERASE && addr == ADDR_WIDTH'(g)) begin
               array_q[g] <= ERASED_WORD;
            end else if (op == OP_WRITE && addr == ADDR_WIDTH'(g)) begin
               array_q[g] <= array_q[g] & shift_q;
            end else if (op == OP_EXTENDED && addr[5:4] == FN_ERASE_ALL) begin
               array_q[g] <= ERASED_WORD;
            end else if (op == OP_EXTENDED && addr[5:4] == FN_WRITE_ALL) begin
               array_q[g] <= array_q[g] & shift_q;
            end
         end
      end
   end

   assign link.serial_out_o = out_q;
   assign link.serial_out_oe_n = oe_n_q;
   assign o_busy = prog_q;
   assign o_writes_enabled = en_q;
endmodule

// File: design/eeprom_host.sv
// ****************************************************************************
// Host end: drives the serial link from a command port
// ****************************************************************************
module eeprom_host (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Command port.
   input wire logic i_cmd_valid,
   input eeprom_pkg::cmd_type i_cmd,
   input wire logic [5:0] i_cmd_addr,
   input wire logic [15:0] i_cmd_data,
   output logic o_cmd_ready,
   // Read data and completion.
   output logic o_rd_valid,
   output logic [15:0] o_rd_data,
   input wire logic i_rd_ready,
   output logic o_done,
   // Serial link.
   serial_link_if.host link
);
   import eeprom_pkg::*;

   typedef enum {
      H_IDLE,
      H_GAP,
      H_SHIFT,
      H_READ,
      H_CS_LOW,
      H_POLL
   } hstate_type;

   hstate_type st_q, st_d;
   logic [24:0] sh_q, sh_d;
   logic [5:0] bits_q, bits_d;
   logic [3:0] div_q, div_d;
   logic [7:0] gap_q, gap_d;
   logic sclk_q, sclk_d, cs_q, cs_d, sin_q, sin_d;
   logic rd_q, rd_d, prog_q, prog_d, done_q, done_d;
   logic [16:0] rx_q, rx_d;
   logic [1:0] so_sync_q;
   logic fifo_ready, fifo_push;
   logic [1:0] opc;
   logic [5:0] adr;
   logic has_data;

   // Returning data bit is synchronised.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         so_sync_q <= 2'b11;
      end else begin
         so_sync_q <= {so_sync_q[0], link.serial_out};
      end
   end

   // Command to instruction mapping.
   always_comb begin
      opc = OP_EXTENDED;
      adr = i_cmd_addr;
      has_data = 1'b0;
      case (i_cmd)
         CMD_READ: opc = OP_READ;
         CMD_WRITE: begin
            opc = OP_WRITE;
            has_data = 1'b1;
         end
         CMD_ERASE: opc = OP_ERASE;
         CMD_ENABLE_WRITES: adr = {FN_ENABLE_WRITES, 4'h0};
         CMD_DISABLE_WRITES: adr = {FN_DISABLE_WRITES, 4'h0};
         CMD_ERASE_ALL: adr = {FN_ERASE_ALL, 4'h0};
         CMD_WRITE_ALL: begin
            adr = {FN_WRITE_ALL, 4'h0};
            has_data = 1'b1;
         end
         default: opc = OP_EXTENDED;
      endcase
   end

   // Link sequencer; serial clock made by a divider.
   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      bits_d = bits_q;
      div_d = div_q;
      gap_d = gap_q;
      sclk_d = sclk_q;
      cs_d = cs_q;
      sin_d = sin_q;
      rd_d = rd_q;
      prog_d = prog_q;
      done_d = 1'b0;
      rx_d = rx_q;
      fifo_push = 1'b0;
      case (st_q)
         H_IDLE: begin
            if (i_cmd_valid && fifo_ready) begin
               sh_d = {1'b1, opc, adr, i_cmd_data};
               bits_d = has_data ? 6'd25 : 6'd9;
               rd_d = (i_cmd == CMD_READ);
               prog_d = (i_cmd == CMD_WRITE || i_cmd == CMD_ERASE || i_cmd == CMD_ERASE_ALL
                  || i_cmd == CMD_WRITE_ALL);
               gap_d = '0;
               st_d = H_GAP;
            end
         end
         H_GAP: begin
            // Select held low before each instruction.
            gap_d = gap_q + 8'h1;
            if (gap_q == 8'(CS_LOW_CYCLES)) begin
               cs_d = 1'b1;
               div_d = '0;
               sin_d = sh_q[24];
               sh_d = {sh_q[23:0], 1'b0};
               bits_d = bits_q - 6'h1;
               st_d = H_SHIFT;
            end
         end
         H_SHIFT, H_READ: begin
            div_d = div_q + 4'h1;
            if (div_q == 4'(SCLK_HALF_CYCLES - 1)) begin
               div_d = '0;
               sclk_d = !sclk_q;
               if (sclk_q) begin
                  // Falling serial clock: present next bit.
                  if (st_q == H_SHIFT && bits_q != '0) begin
                     sin_d = sh_q[24];
                     sh_d = {sh_q[23:0], 1'b0};
                     bits_d = bits_q - 6'h1;
                  end else if (st_q == H_SHIFT) begin
                     sin_d = 1'b0;
                     if (rd_q) begin
                        bits_d = 6'd17;
                        st_d = H_READ;
                     end else begin
                        // Drop select before the next rising edge.
                        cs_d = 1'b0;
                        gap_d = '0;
                        st_d = H_CS_LOW;
                     end
                  end else if (bits_q == '0) begin
                     cs_d = 1'b0;
                     gap_d = '0;
                     fifo_push = 1'b1;
                     st_d = H_CS_LOW;
                  end
               end else if (st_q == H_READ && bits_q != '0) begin
                  // Sample dummy then data just before each rising edge.
                  rx_d = {rx_q[15:0], so_sync_q[1]};
                  bits_d = bits_q - 6'h1;
               end
            end
         end
         H_CS_LOW: begin
            gap_d = gap_q + 8'h1;
            if (gap_q == 8'(CS_LOW_CYCLES)) begin
               gap_d = '0;
               if (prog_q) begin
                  cs_d = 1'b1;
                  st_d = H_POLL;
               end else begin
                  done_d = 1'b1;
                  st_d = H_IDLE;
               end
            end
         end
         H_POLL: begin
            // Wait for ready status with the clock stopped.
            gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h1;
            if (gap_q > 8'h10 && so_sync_q[1]) begin
               cs_d = 1'b0;
               prog_d = 1'b0;
               gap_d = '0;
               st_d = H_CS_LOW;
            end
         end
         default: st_d = H_IDLE;
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= H_IDLE;
         sh_q <= '0;
         bits_q <= '0;
         div_q <= '0;
         gap_q <= '0;
         sclk_q <= 1'b0;
         cs_q <= 1'b0;
         sin_q <= 1'b0;
         rd_q <= 1'b0;
         prog_q <= 1'b0;
         done_q <= 1'b0;
         rx_q <= '0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         bits_q <= bits_d;
         div_q <= div_d;
         gap_q <= gap_d;
         sclk_q <= sclk_d;
         cs_q <= cs_d;
         sin_q <= sin_d;
         rd_q <= rd_d;
         prog_q <= prog_d;
         done_q <= done_d;
         rx_q <= rx_d;
      end
   end

   // Read words are buffered; a full buffer stalls new commands.
   sync_fifo #(
      .WIDTH(DATA_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_rd_fifo (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_in_valid(fifo_push),
      .i_in_data(rx_q[15:0]),
      .o_in_ready(fifo_ready),
      .o_out_valid(o_rd_valid),
      .o_out_data(o_rd_data),
      .i_out_ready(i_rd_ready)
   );

   assign o_cmd_ready = (st_q == H_IDLE) && fifo_ready;
   assign o_done = done_q;
   assign link.chip_select = cs_q;
   assign link.serial_clock = sclk_q;
   assign link.serial_in = sin_q;
endmodule

// File: tb/eeprom_link_assertions.sv
// *****
// Link watcher
// *****
module eeprom_link_assertions #(
   parameter int PROG_CYCLES = 50
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Link wires.
   input wire logic chip_select,
   input wire logic serial_clock,
   input wire logic serial_in,
   input wire logic serial_out_o,
   input wire logic serial_out_oe_n,
   input wire logic serial_out
);
   logic sclk_q;
   logic sclk_rise;
   logic [4:0] rise_q, rise_d;
   logic [3:0] low_q, low_d;
   logic [7:0] stat_q, stat_d;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   // Counts clock rises in a frame, idle clock time and busy status time.
   always_comb begin
      sclk_rise = serial_clock && !sclk_q;
      rise_d = chip_select ? rise_q + {4'h0, sclk_rise} : 5'h00;
      low_d = serial_clock ? 4'h0 : low_q + {3'h0, low_q != 4'hf};
      stat_d = (chip_select && !serial_clock && !serial_out_oe_n && !serial_out_o) ? stat_q + 8'h01 : 8'h00;
   end

   // Registers the helper counts.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sclk_q <= 1'b0;
         rise_q <= 5'h00;
         low_q <= 4'h0;
         stat_q <= 8'h00;
      end else begin
         sclk_q <= serial_clock;
         rise_q <= rise_d;
         low_q <= low_d;
         stat_q <= stat_d;
      end
   end

   // Select held low for eight cycles.
   sequence cs_idle_s;
      !chip_select [*8];
   endsequence

   chk_start_bit: assert property (sclk_rise && chip_select && rise_q == 5'h00 |-> serial_in)
      else $error("frame does not open with a one bit");
   // A read frame carries one more rise than a write, for the dummy bit.
   chk_frame_length: assert property (sclk_rise && chip_select |-> rise_q < (serial_out_oe_n ? 5'h19 : 5'h1a))
      else $error("too many clock rises in a frame");
   chk_dummy_zero: assert property ($fell(serial_out_oe_n) && rise_q == 5'h09 |-> !serial_out_o)
      else $error("read output does not open with a zero");
   chk_out_release: assert property (cs_idle_s |-> serial_out_oe_n && serial_out)
      else $error("output driven while deselected");
   chk_clock_idle: assert property (cs_idle_s |-> !serial_clock)
      else $error("serial clock runs while deselected");
   chk_read_edge: assert property ($changed(serial_out_o) && !serial_out_oe_n && $past(serial_out_oe_n) == 1'b0
      |-> serial_clock || low_q < 4'h2 || low_q == 4'hf)
      else $error("read output changed away from a clock rise");
   chk_status_bound: assert property (chip_select |-> stat_q < PROG_CYCLES + 20)
      else $error("busy status lasts too long");
   chk_select_gap: assert property ($fell(chip_select) |-> ##1 cs_idle_s ##1 !chip_select)
      else $error("select low gap too short");
endmodule

// File: tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import eeprom_pkg::*;

   // *****
   // Signals and instances
   // *****
   localparam int PROG = 50;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_cmd_valid = 1'b0;
   cmd_type i_cmd = CMD_READ;
   logic [5:0] i_cmd_addr = 6'h00;
   logic [15:0] i_cmd_data = 16'h0000;
   logic i_rd_ready = 1'b0;
   logic o_cmd_ready, o_rd_valid, o_done, busy, wr_en;
   logic [15:0] o_rd_data;
   logic [15:0] mem_m [64];
   logic [15:0] exp_q [$];
   logic [31:0] seed = 32'h3f96_e221;
   cmd_type kinds [4] = '{CMD_WRITE, CMD_ERASE, CMD_ERASE_ALL, CMD_WRITE_ALL};
   bit en_m;
   int num_errors, num_checks, cycles, busy_cycles;

   serial_link_if link ();
   eeprom_memory #(.PROG_CYCLES(PROG)) eeprom_memory_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(link),
      .o_busy(busy), .o_writes_enabled(wr_en));
   eeprom_host eeprom_host_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
      .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready), .o_rd_valid(o_rd_valid),
      .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready), .o_done(o_done), .link(link));
   eeprom_link_assertions #(.PROG_CYCLES(PROG)) eeprom_link_assertions_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .chip_select(link.chip_select), .serial_clock(link.serial_clock), .serial_in(link.serial_in),
      .serial_out_o(link.serial_out_o), .serial_out_oe_n(link.serial_out_oe_n), .serial_out(link.serial_out));

   // *****
   // Clock, timeout and tasks
   // *****
   // The clock toggles every half period of 100 ns.
   always #50 i_clk = ~i_clk;

   // Cuts a hung run short.
   always @(posedge i_clk) begin
      cycles++;
      // Counts cycles with a programming cycle running.
      if (busy === 1'b1) begin
         busy_cycles++;
      end
      if (cycles == 60000) begin
         num_errors++;
         stop_test();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Hands one command over and keeps the model in step with it.
   task automatic send(input cmd_type c, input logic [5:0] a, input logic [15:0] d);
      i_cmd_valid <= 1'b1;
      i_cmd <= c;
      i_cmd_addr <= a;
      i_cmd_data <= d;
      do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
      i_cmd_valid <= 1'b0;
      case (c)
         CMD_READ: exp_q.push_back(mem_m[a]);
         CMD_WRITE: if (en_m) mem_m[a] &= d;
         CMD_ERASE: if (en_m) mem_m[a] = 16'hffff;
         CMD_ENABLE_WRITES: en_m = 1'b1;
         CMD_DISABLE_WRITES: en_m = 1'b0;
         CMD_ERASE_ALL: if (en_m) foreach (mem_m[i]) mem_m[i] = 16'hffff;
         default: if (en_m) foreach (mem_m[i]) mem_m[i] &= d;
      endcase
      do @(posedge i_clk); while (c != CMD_READ && o_done !== 1'b1);
   endtask

   // Drains read words and compares them with the model.
   task automatic end_test(input string name);
      i_rd_ready <= 1'b1;
      while (exp_q.size() > 0) begin
         @(posedge i_clk);
         if (o_rd_valid === 1'b1) check(o_rd_data, exp_q.pop_front());
      end
      i_rd_ready <= 1'b0;
      $display("test %s finished at %0t", name, $time);
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // *****
   // Main sequence
   // *****
   initial begin
      repeat (3) @(posedge i_clk);
      i_reset_n <= 1'b1;
      check({15'h0000, wr_en}, 16'h0000);
      send(CMD_ENABLE_WRITES, 6'h0a, 16'h0000);
      check({15'h0000, wr_en}, 16'h0001);
      send(CMD_ERASE_ALL, 6'h00, 16'h0000);
      send(CMD_READ, 6'h00, 16'h0000);
      send(CMD_READ, 6'h3f, 16'h0000);
      seed = lfsr(seed);
      send(CMD_WRITE_ALL, 6'h00, seed[15:0]);
      send(CMD_READ, 6'h15, 16'h0000);
      end_test("whole array");
      check(16'(busy_cycles), 16'(2 * PROG));
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         send(CMD_ERASE, seed[21:16], 16'h0000);
         send(CMD_WRITE, seed[21:16], seed[15:0]);
         send(CMD_WRITE, seed[21:16], seed[31:16]);
         send(CMD_READ, seed[21:16], 16'h0000);
         send(CMD_READ, seed[21:16] ^ 6'h01, 16'h0000);
      end
      end_test("single registers");
      check(16'(busy_cycles), 16'(26 * PROG));
      send(CMD_DISABLE_WRITES, 6'h05, 16'h0000);
      check({15'h0000, wr_en}, 16'h0000);
      foreach (kinds[k]) begin
         send(kinds[k], seed[5:0], 16'h0000);
         send(CMD_READ, seed[5:0], 16'h0000);
      end
      end_test("writes disabled");
      check(16'(busy_cycles), 16'(26 * PROG));
      for (int k = 0; k < 32; k++) begin
         seed = lfsr(seed);
         send(CMD_READ, seed[5:0], 16'h0000);
      end
      repeat (600) @(posedge i_clk);
      check({15'h0000, o_cmd_ready}, 16'h0000);
      end_test("buffer full");
      repeat (2) @(posedge i_clk);
      check({15'h0000, o_cmd_ready}, 16'h0001);
      stop_test();
   end
endmodule
